//--- dcap_top.sv
// debug control access port: serial-wire link, control registers, erase and mailbox
`timescale 1ns/1ns
module dcap_top #(
	parameter logic [31:0] IDENT_VALUE = 32'h0000_1234, // arbitrary value
	parameter logic [31:0] DP_IDENT_VALUE = 32'h0000_5678, // arbitrary value
	parameter logic [31:0] RELEASE_KEY = 32'h0000_0001
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        swdclk_i,
	input  wire logic        swdio_i,
	output logic             swdio_o,
	output logic             swdio_oe_o,
	input  wire logic        cfg_ap_prot_i,
	input  wire logic        cfg_sec_prot_i,
	input  wire logic        cfg_er_lock_i,
	output logic             cpu_ap_block_o,
	output logic             secure_dbg_block_o,
	output logic             dbg_flash_ok_o,
	output logic             soft_reset_o,
	output logic             reset_reason_o,
	input  wire logic        reason_clr_i,
	output logic             erase_app_o,
	output logic             erase_net_o,
	input  wire logic        erase_app_done_i,
	input  wire logic        erase_net_done_i,
	output logic             erase_busy_o,
	output logic [31:0]      fw_out_word_o,
	output logic             fw_out_pend_o,
	input  wire logic        fw_out_take_i,
	input  wire logic [31:0] fw_in_word_i,
	input  wire logic        fw_in_put_i,
	output logic             fw_in_pend_o,
	input  wire logic        fw_release_i,
	input  wire logic [31:0] fw_release_word_i
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0]           rs_q;
	logic                 rst_n;
	dcap_pkg::dcap_state_t q;
	dcap_pkg::dcap_state_t n;
	logic                 rise;
	logic [7:0]           ap_addr;
	logic [31:0]          rdat;
	logic [32:0]          wsh;
	logic                 lock_act;
	logic                 er_go;
	logic                 out_clr;
	logic                 in_clr;
	logic                 out_set;

	// asynchronous assert, two-stage release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rs_q <= 2'b00;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	// even parity helper for data words; request parity is checked inline
	function automatic logic par32(input logic [31:0] v);
		par32 = ^v;
	endfunction

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		n = q;
		// the first stage of each synchroniser feeds only the second
		n.ck_s1 = swdclk_i;
		n.ck_s2 = q.ck_s1;
		n.ck_prev = q.ck_s2;
		n.io_s1 = swdio_i;
		n.io_s2 = q.io_s1;
		rise = q.ck_s2 & ~q.ck_prev;
		n.soft_rst = 1'b0;
		er_go = 1'b0;
		out_clr = 1'b0;
		in_clr = 1'b0;
		out_set = 1'b0;
		lock_act = q.er_lock & ~q.unlocked;
		ap_addr = {q.sel_bank, q.req[3:2], 2'b00};
		wsh = {q.io_s2, q.sh[32:1]};

		// protection is taken once after reset, so a debugger erase lifts it only at the next one; the two-party unlock clears it at once
		if (!q.cfg_ld) begin
			n.cfg_ld = 1'b1;
			n.ap_prot = cfg_ap_prot_i;
			n.sec_prot = cfg_sec_prot_i;
			n.er_lock = cfg_er_lock_i;
		end

		// read mux; write-only registers read zero
		rdat = '0;
		if (q.req[0]) begin
			if (q.sel_ap == dcap_pkg::CONTROL_ACCESS_PORT_SEL) begin
				case (ap_addr)
					dcap_pkg::OFS_ER_STAT:  rdat[0] = q.er != dcap_pkg::ER_IDLE;
					dcap_pkg::OFS_PROT:     rdat[1:0] = {~q.sec_prot, ~q.ap_prot};
					dcap_pkg::OFS_LOCK:     rdat[0] = ~lock_act;
					dcap_pkg::OFS_OUT_ST:   rdat[0] = q.out_pend;
					dcap_pkg::OFS_IN_WORD:  rdat = q.in_word;
					dcap_pkg::OFS_IN_ST:    rdat[0] = q.in_pend;
					dcap_pkg::OFS_IDENT:    rdat = IDENT_VALUE;
					default:                rdat = '0;
				endcase
			end
		end else begin
			case (q.req[3:2])
				dcap_pkg::DP_IDENT:  rdat = DP_IDENT_VALUE;
				dcap_pkg::DP_RDBUFF: rdat = q.rdbuf;
				default:             rdat = '0;
			endcase
		end

		// ---------------------------------------------------------------
		// link framing, one step per sampled rising edge of the link clock
		// ---------------------------------------------------------------
		if (rise) begin
			unique case (q.st)
				dcap_pkg::ST_IDLE: begin
					n.io_oe = 1'b0;
					if (q.io_s2) begin
						n.st = dcap_pkg::ST_REQ;
						n.cnt = '0;
					end
				end
				dcap_pkg::ST_REQ: begin
					n.req = {q.io_s2, q.req[6:1]};
					n.cnt = q.cnt + 6'h01;
					if (q.cnt == dcap_pkg::REQ_BITS - 6'h01) begin
						// bad parity, stop or park: stay silent, as on a line reset
						if ((^n.req[3:0]) == n.req[4] && !n.req[5] && n.req[6]) begin
							n.st = dcap_pkg::ST_TRN;
						end else begin
							n.st = dcap_pkg::ST_IDLE;
						end
					end
				end
				dcap_pkg::ST_TRN: begin
					// answer always OK: this port stays usable under protection
					n.st = dcap_pkg::ST_ACK;
					n.io_oe = 1'b1;
					n.io_o = dcap_pkg::ACK_OK[0];
					n.cnt = 6'h01;
					if (q.req[1]) begin
						n.sh = {par32(rdat), rdat};
						if (q.req[0]) begin
							n.rdbuf = rdat;
							if (q.sel_ap == dcap_pkg::CONTROL_ACCESS_PORT_SEL && ap_addr == dcap_pkg::OFS_IN_WORD) begin
								in_clr = 1'b1;
							end
						end
					end
				end
				dcap_pkg::ST_ACK: begin
					n.cnt = q.cnt + 6'h01;
					if (q.cnt == dcap_pkg::ACK_BITS) begin
						n.cnt = '0;
						if (q.req[1]) begin
							n.st = dcap_pkg::ST_RDATA;
							n.io_o = q.sh[0];
							n.sh = {1'b0, q.sh[32:1]};
						end else begin
							n.st = dcap_pkg::ST_WTRN;
							n.io_oe = 1'b0;
						end
					end else begin
						n.io_o = dcap_pkg::ACK_OK[q.cnt[1:0]];
					end
				end
				dcap_pkg::ST_RDATA: begin
					n.cnt = q.cnt + 6'h01;
					n.io_o = q.sh[0];
					n.sh = {1'b0, q.sh[32:1]};
					if (q.cnt == dcap_pkg::DATA_BITS - 6'h01) begin
						n.st = dcap_pkg::ST_END;
						n.io_oe = 1'b0;
					end
				end
				dcap_pkg::ST_WTRN: begin
					n.st = dcap_pkg::ST_WDATA;
					n.cnt = '0;
				end
				dcap_pkg::ST_WDATA: begin
					n.sh = wsh;
					n.cnt = q.cnt + 6'h01;
					if (q.cnt == dcap_pkg::DATA_BITS - 6'h01) begin
						n.st = dcap_pkg::ST_IDLE;
						// a word with bad parity is dropped
						if (par32(wsh[31:0]) == wsh[32]) begin
							if (!q.req[0]) begin
								if (q.req[3:2] == dcap_pkg::DP_SELECT) begin
									n.sel_ap = wsh[dcap_pkg::SEL_AP_LSB +: 8];
									n.sel_bank = wsh[dcap_pkg::SEL_BANK_LSB +: 4];
								end
							end else if (q.sel_ap == dcap_pkg::CONTROL_ACCESS_PORT_SEL) begin
								case (ap_addr)
									dcap_pkg::OFS_RESET: begin
										if (wsh[dcap_pkg::FLD_EN] && !q.rst_blk) begin
											n.soft_rst = 1'b1;
										end
									end
									dcap_pkg::OFS_ERASE: begin
										if (wsh[dcap_pkg::FLD_EN]) begin
											n.rst_blk = 1'b1;
											// locked device refuses, busy one ignores
											if (!lock_act && q.er == dcap_pkg::ER_IDLE) begin
												er_go = 1'b1;
											end
										end
									end
									dcap_pkg::OFS_RELEASE: begin
										if (!q.dbg_rel_wr) begin
											n.dbg_rel_wr = 1'b1;
											n.dbg_rel_ok = wsh[31:0] == RELEASE_KEY;
										end
									end
									dcap_pkg::OFS_OUT_WORD: begin
										n.out_word = wsh[31:0];
										out_set = 1'b1;
									end
									default: ;
								endcase
							end
						end
					end
				end
				dcap_pkg::ST_END: begin
					n.st = dcap_pkg::ST_IDLE;
				end
			endcase
		end

		// ---------------------------------------------------------------
		// firmware side of the unlock and mailbox
		// ---------------------------------------------------------------
		// the firmware release register is write-once too, so a start-up write seals it
		if (fw_release_i && !q.fw_rel_wr) begin
			n.fw_rel_wr = 1'b1;
			n.fw_rel_ok = fw_release_word_i == RELEASE_KEY;
		end
		if (fw_out_take_i) begin
			out_clr = 1'b1;
		end
		// a single flag per direction serves both ends, so both views change together
		n.out_pend = out_set | (q.out_pend & ~out_clr);
		if (fw_in_put_i) begin
			n.in_word = fw_in_word_i;
		end
		n.in_pend = fw_in_put_i | (q.in_pend & ~in_clr);

		// soft reset reason; a new request wins over a firmware clear
		n.reason = n.soft_rst | (q.reason & ~reason_clr_i);

		// ---------------------------------------------------------------
		// full erase sequencer
		// ---------------------------------------------------------------
		if (q.dbg_rel_ok && q.fw_rel_ok && !q.unlocked && !q.auto_er && q.er == dcap_pkg::ER_IDLE && !er_go) begin
			er_go = 1'b1;
			n.auto_er = 1'b1;
		end
		unique case (q.er)
			dcap_pkg::ER_IDLE: begin
				if (er_go) begin
					n.er = dcap_pkg::ER_APP;
				end
			end
			dcap_pkg::ER_APP: begin
				// application side goes first, ignoring its own protection
				if (erase_app_done_i) begin
					n.er = dcap_pkg::ER_NET;
				end
			end
			dcap_pkg::ER_NET: begin
				if (erase_net_done_i) begin
					n.er = dcap_pkg::ER_IDLE;
					// only the two-party unlock opens the port at once
					if (q.auto_er) begin
						n.auto_er = 1'b0;
						n.unlocked = 1'b1;
						n.ap_prot = 1'b0;
						n.sec_prot = 1'b0;
					end
				end
			end
			default: n.er = dcap_pkg::ER_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// access gating toward the rest of the debug complex
	assign cpu_ap_block_o     = q.ap_prot;
	assign secure_dbg_block_o = q.sec_prot;
	assign dbg_flash_ok_o     = ~q.ap_prot;
	assign soft_reset_o       = q.soft_rst;
	assign reset_reason_o     = q.reason;
	assign erase_app_o        = q.er == dcap_pkg::ER_APP;
	assign erase_net_o        = q.er == dcap_pkg::ER_NET;
	assign erase_busy_o       = q.er != dcap_pkg::ER_IDLE;
	assign fw_out_word_o      = q.out_word;
	assign fw_out_pend_o      = q.out_pend;
	assign fw_in_pend_o       = q.in_pend;
	assign swdio_o            = q.io_o;
	assign swdio_oe_o         = q.io_oe;
endmodule

//--- dcap_pkg.sv
// shared constants and types for the debug control access port
package dcap_pkg;
	// ---------------------------------------------------------------
	// control access port register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_RESET    = 8'h00;
	localparam logic [7:0] OFS_ERASE    = 8'h04;
	localparam logic [7:0] OFS_ER_STAT  = 8'h08;
	localparam logic [7:0] OFS_PROT     = 8'h0c;
	localparam logic [7:0] OFS_LOCK     = 8'h18;
	localparam logic [7:0] OFS_RELEASE  = 8'h1c;
	localparam logic [7:0] OFS_OUT_WORD = 8'h20;
	localparam logic [7:0] OFS_OUT_ST   = 8'h24;
	localparam logic [7:0] OFS_IN_WORD  = 8'h28;
	localparam logic [7:0] OFS_IN_ST    = 8'h2c;
	localparam logic [7:0] OFS_IDENT    = 8'hfc;
	// ---------------------------------------------------------------
	// debug port addresses and select fields
	// ---------------------------------------------------------------
	localparam logic [1:0] DP_IDENT     = 2'h0;
	localparam logic [1:0] DP_SELECT    = 2'h2;
	localparam logic [1:0] DP_RDBUFF    = 2'h3;
	localparam int         SEL_AP_LSB   = 24;
	localparam int         SEL_BANK_LSB = 4;
	localparam logic [7:0] CONTROL_ACCESS_PORT_SEL  = 8'h04;
	// ---------------------------------------------------------------
	// link framing
	// ---------------------------------------------------------------
	localparam logic [2:0] ACK_OK       = 3'h1;
	localparam logic [5:0] REQ_BITS     = 6'h07;
	localparam logic [5:0] ACK_BITS     = 6'h03;
	localparam logic [5:0] DATA_BITS    = 6'h21;
	localparam int         FLD_EN       = 0;
	// ---------------------------------------------------------------
	// state types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_TRN, ST_ACK, ST_RDATA, ST_WTRN, ST_WDATA, ST_END} dcap_swd_t;
	typedef enum logic [1:0] {ER_IDLE, ER_APP, ER_NET} dcap_er_t;
	typedef struct packed {
		logic ck_s1; logic ck_s2; logic ck_prev; logic io_s1; logic io_s2;
		dcap_swd_t st; logic [5:0] cnt; logic [6:0] req; logic [32:0] sh;
		logic io_o; logic io_oe; logic [7:0] sel_ap; logic [3:0] sel_bank; logic [31:0] rdbuf;
		logic cfg_ld; logic ap_prot; logic sec_prot; logic er_lock;
		dcap_er_t er; logic auto_er; logic unlocked; logic rst_blk; logic soft_rst; logic reason;
		logic dbg_rel_wr; logic dbg_rel_ok; logic fw_rel_wr; logic fw_rel_ok;
		logic [31:0] out_word; logic out_pend; logic [31:0] in_word; logic in_pend;
	} dcap_state_t;
endpackage

//--- dcap_top_assertions.sv
// assertion checker for the debug control access port, bound to its top
`timescale 1ns/1ns
module dcap_checker (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        cpu_ap_block_o,
	input wire logic        dbg_flash_ok_o,
	input wire logic        soft_reset_o,
	input wire logic        reset_reason_o,
	input wire logic        reason_clr_i,
	input wire logic        erase_app_o,
	input wire logic        erase_net_o,
	input wire logic        erase_app_done_i,
	input wire logic        erase_net_done_i,
	input wire logic        erase_busy_o,
	input wire logic [31:0] fw_out_word_o,
	input wire logic        fw_out_pend_o,
	input wire logic        fw_out_take_i,
	input wire logic        fw_in_put_i,
	input wire logic        fw_in_pend_o
);
	logic [2:0] up_q;
	// protection outputs settle a few cycles after release, so wait them out
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_q <= 3'h0;
		end else if (up_q != 3'h7) begin
			up_q <= up_q + 3'h1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// erase sequencing and status
	busy_phases_a: assert property (erase_busy_o == (erase_app_o | erase_net_o))
		else $error("busy flag disagrees with erase phases");
	one_phase_a: assert property (!(erase_app_o && erase_net_o))
		else $error("both erase phases active");
	app_first_a: assert property ($rose(erase_busy_o) |-> erase_app_o)
		else $error("erase did not begin on the application side");
	app_done_a: assert property (erase_app_o && erase_app_done_i |=> erase_net_o && !erase_app_o)
		else $error("slave phase did not follow application phase");
	net_done_a: assert property (erase_net_o && erase_net_done_i |=> !erase_busy_o)
		else $error("erase still busy after last phase");
	// protection, soft reset and mailbox
	flash_prot_a: assert property (up_q == 3'h7 |-> dbg_flash_ok_o != cpu_ap_block_o)
		else $error("flash access and port block disagree");
	reset_pulse_a: assert property (soft_reset_o |-> reset_reason_o ##1 !soft_reset_o)
		else $error("soft reset not a single pulse with reason");
	reason_clr_a: assert property (reason_clr_i |=> !reset_reason_o || soft_reset_o)
		else $error("reset reason not cleared");
	in_set_a: assert property (fw_in_put_i |=> fw_in_pend_o)
		else $error("inbound word not marked waiting");
	out_clr_a: assert property (fw_out_take_i |=> !fw_out_pend_o)
		else $error("outbound word still waiting after take");
	word_hold_a: assert property ($changed(fw_out_word_o) |-> fw_out_pend_o)
		else $error("outbound word changed without a write");
	erase_run_c: cover property (erase_net_o && erase_net_done_i);
	take_c: cover property (fw_out_take_i && fw_out_pend_o);
	soft_reset_c: cover property (soft_reset_o);
endmodule
bind dcap_top dcap_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .cpu_ap_block_o(cpu_ap_block_o),
	.dbg_flash_ok_o(dbg_flash_ok_o), .soft_reset_o(soft_reset_o), .reset_reason_o(reset_reason_o),
	.reason_clr_i(reason_clr_i), .erase_app_o(erase_app_o), .erase_net_o(erase_net_o),
	.erase_app_done_i(erase_app_done_i), .erase_net_done_i(erase_net_done_i), .erase_busy_o(erase_busy_o),
	.fw_out_word_o(fw_out_word_o), .fw_out_pend_o(fw_out_pend_o), .fw_out_take_i(fw_out_take_i),
	.fw_in_put_i(fw_in_put_i), .fw_in_pend_o(fw_in_pend_o));

//--- dcap_dbg_model.sv
// serial-wire debugger model for the link side of the control access port
`timescale 1ns/1ns
module dcap_dbg_model (
	input  wire logic clk_i,
	input  wire logic dev_d_i,
	input  wire logic dev_oe_i,
	output logic      swdclk_o,
	output logic      line_o
);
	logic hd_q;
	logic hoe_q;
	// the data line has a pull-up, so a released line reads high
	assign line_o = dev_oe_i ? dev_d_i : (hoe_q ? hd_q : 1'b1);
	// link clock idles low between frames
	initial begin
		swdclk_o = 1'b0;
		hd_q = 1'b0;
		hoe_q = 1'b0;
	end
	// one bit: data set in the low phase, line sampled just before the rise
	task automatic bitc(input logic oe, input logic d, output logic s);
		@(posedge clk_i) hoe_q <= oe;
		hd_q <= d;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) s = line_o;
		@(posedge clk_i) swdclk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		swdclk_o <= 1'b0;
	endtask
	// one packet, lsb first; a = {A3, A2}; pe is set on a bad read parity
	task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic [2:0] ack, output logic pe);
		logic [7:0] rq;
		logic s;
		logic d;
		rq = {2'b10, ^{ap, rnw, a}, a, rnw, ap, 1'b1};
		rd = '0;
		ack = '0;
		pe = 1'b0;
		for (int i = 0; i < 48; i++) begin
			d = (i < 8) ? rq[i] : (!rnw && i >= 13 && i < 45) ? wd[i - 13] : (!rnw && i == 45) ? ^wd : 1'b0;
			bitc(i < 8 || (rnw ? i >= 45 : i >= 12), d, s);
			if (i >= 9 && i < 12) ack[i - 9] = s;
			if (rnw && i >= 12 && i < 44) rd[i - 12] = s;
			if (rnw && i == 44) pe = s ^ (^rd);
		end
	endtask
endmodule

//--- dcap_top_tb_top.sv
// self-checking bench for the debug control access port
`timescale 1ns/1ns
module dcap_top_tb_top;
	localparam logic [31:0] ID_V = 32'h0000_00a5; // arbitrary value
	localparam logic [31:0] DP_ID_V = 32'h0000_00c3; // arbitrary value
	logic        clk_i;
	logic        nrst_i;
	logic        cap;
	logic        csec;
	logic        clk_lock;
	logic [5:0]  stb;
	logic [31:0] in_word;
	logic [31:0] rel_word;
	logic        swdclk;
	logic        line;
	logic        sdo;
	logic        soe;
	logic        blk;
	logic        sblk;
	logic        fok;
	logic        srst;
	logic        reason;
	logic        e_app;
	logic        e_net;
	logic        busy;
	logic        out_pend;
	logic        in_pend;
	logic [31:0] out_word;
	int          fail_count;
	int          checked;
	int          sr_cnt;
	// strobe bits: 0 reason clear, 1 app done, 2 slave done, 3 take, 4 put, 5 release
	dcap_top #(.IDENT_VALUE(ID_V), .DP_IDENT_VALUE(DP_ID_V)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
		.swdclk_i(swdclk), .swdio_i(line), .swdio_o(sdo), .swdio_oe_o(soe), .cfg_ap_prot_i(cap),
		.cfg_sec_prot_i(csec), .cfg_er_lock_i(clk_lock), .cpu_ap_block_o(blk), .secure_dbg_block_o(sblk),
		.dbg_flash_ok_o(fok), .soft_reset_o(srst), .reset_reason_o(reason), .reason_clr_i(stb[0]),
		.erase_app_o(e_app), .erase_net_o(e_net),
		.erase_app_done_i(stb[1]), .erase_net_done_i(stb[2]), .erase_busy_o(busy), .fw_out_word_o(out_word),
		.fw_out_pend_o(out_pend), .fw_out_take_i(stb[3]), .fw_in_word_i(in_word), .fw_in_put_i(stb[4]),
		.fw_in_pend_o(in_pend), .fw_release_i(stb[5]), .fw_release_word_i(rel_word));
	dcap_dbg_model u_dbg (.clk_i(clk_i), .dev_d_i(sdo), .dev_oe_i(soe), .swdclk_o(swdclk), .line_o(line));
	// 100 MHz system clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// count soft reset pulses seen on the output
	always @(posedge clk_i) begin
		if (srst === 1'b1) sr_cnt++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// select the control port bank, then one access on it
	task automatic acc(input logic rnw, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		logic [2:0] a0;
		logic [2:0] a1;
		logic pe;
		u_dbg.xfer(1'b0, 1'b0, 2'b10, {dcap_pkg::CONTROL_ACCESS_PORT_SEL, 16'h0000, adr[7:4], 4'h0}, rd, a0, pe);
		u_dbg.xfer(1'b1, rnw, adr[3:2], wd, rd, a1, pe);
		chk({26'h0, a0, a1}, {26'h0, dcap_pkg::ACK_OK, dcap_pkg::ACK_OK});
		chk({31'h0, pe}, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] r;
		acc(1'b1, adr, 32'h0, r);
		chk(r, exp);
	endtask
	// one read of a debug port register, no bank select needed
	task automatic dprd(input logic [1:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic [2:0] k;
		logic pe;
		u_dbg.xfer(1'b0, 1'b1, a, 32'h0, r, k, pe);
		chk({29'h0, k}, {29'h0, dcap_pkg::ACK_OK});
		chk(r, exp);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] r;
		acc(1'b0, adr, d, r);
	endtask
	task automatic pls(input int k);
		@(posedge clk_i) stb[k] <= 1'b1;
		@(posedge clk_i) stb[k] <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic do_reset(input logic ap, input logic sec, input logic lk);
		@(posedge clk_i) nrst_i <= 1'b0;
		cap <= ap;
		csec <= sec;
		clk_lock <= lk;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
	endtask
	// a hang counts as a failure
	initial begin
		repeat (60000) @(posedge clk_i);
		fail_count++;
		complete_run();
	end
	initial begin
		nrst_i = 1'b0;
		{cap, csec, clk_lock, stb, in_word, rel_word} = '0;
		do_reset(1'b1, 1'b0, 1'b0);
		chk({30'h0, sblk, blk}, 32'h1);
		rdc(dcap_pkg::OFS_IDENT, ID_V);
		dprd(dcap_pkg::DP_RDBUFF, ID_V);
		dprd(dcap_pkg::DP_IDENT, DP_ID_V);
		rdc(dcap_pkg::OFS_PROT, 32'h2);
		rdc(dcap_pkg::OFS_LOCK, 32'h1);
		rdc(dcap_pkg::OFS_ER_STAT, 32'h0);
		rdc(8'h10, 32'h0);
		$display("test status done");
		wr(dcap_pkg::OFS_OUT_WORD, 32'hcafe_0123);
		chk(out_word, 32'hcafe_0123);
		rdc(dcap_pkg::OFS_OUT_ST, 32'h1);
		pls(3);
		rdc(dcap_pkg::OFS_OUT_ST, 32'h0);
		in_word <= 32'h1357_9bdf;
		pls(4);
		rdc(dcap_pkg::OFS_IN_ST, 32'h1);
		rdc(dcap_pkg::OFS_IN_WORD, 32'h1357_9bdf);
		rdc(dcap_pkg::OFS_IN_ST, 32'h0);
		chk({31'h0, in_pend}, 32'h0);
		rdc(dcap_pkg::OFS_IN_WORD, 32'h1357_9bdf);
		$display("test mailbox done");
		wr(dcap_pkg::OFS_RESET, 32'h1);
		chk(32'(sr_cnt), 32'h1);
		chk({31'h0, reason}, 32'h1);
		pls(0);
		chk({31'h0, reason}, 32'h0);
		$display("test soft reset done");
		wr(dcap_pkg::OFS_ERASE, 32'h1);
		chk({30'h0, e_app, busy}, 32'h3);
		rdc(dcap_pkg::OFS_ER_STAT, 32'h1);
		pls(1);
		chk({30'h0, e_app, e_net}, 32'h1);
		rdc(dcap_pkg::OFS_ER_STAT, 32'h1);
		pls(2);
		chk({31'h0, busy}, 32'h0);
		wr(dcap_pkg::OFS_RESET, 32'h1);
		chk(32'(sr_cnt), 32'h1);
		rdc(dcap_pkg::OFS_PROT, 32'h2);
		$display("test erase done");
		// secure protection on here, so the unlock must visibly clear it
		do_reset(1'b0, 1'b1, 1'b1);
		chk({30'h0, sblk, fok}, 32'h3);
		rdc(dcap_pkg::OFS_LOCK, 32'h0);
		rdc(dcap_pkg::OFS_PROT, 32'h1);
		wr(dcap_pkg::OFS_ERASE, 32'h1);
		chk({31'h0, busy}, 32'h0);
		wr(dcap_pkg::OFS_RESET, 32'h1);
		chk(32'(sr_cnt), 32'h1);
		wr(dcap_pkg::OFS_RELEASE, 32'h1);
		chk({31'h0, busy}, 32'h0);
		rel_word <= 32'h1;
		pls(5);
		repeat (4) @(negedge clk_i);
		chk({31'h0, busy}, 32'h1);
		pls(1);
		pls(2);
		rdc(dcap_pkg::OFS_LOCK, 32'h1);
		chk({30'h0, sblk, blk}, 32'h0);
		rdc(dcap_pkg::OFS_PROT, 32'h3);
		$display("test unlock done");
		do_reset(1'b0, 1'b0, 1'b1);
		// firmware seals its release register first thing after start-up
		pls(5);
		wr(dcap_pkg::OFS_RELEASE, 32'h0);
		wr(dcap_pkg::OFS_RELEASE, 32'h1);
		repeat (4) @(negedge clk_i);
		chk({31'h0, busy}, 32'h0);
		$display("test single release done");
		complete_run();
	end
endmodule
